// ---- hdl/i2c_byte_engine.v ----
// I2C master byte engine: start, stop, byte write and byte read.
// Assumes sda_in is already synchronised; pins are open drain, oe pulls low.
`timescale 1ns/100ps
`include "id_rom_defs.vh"

module i2c_byte_engine #(
  parameter QUARTER = `SCL_QUARTER_CYC
) (
  input wire clk, // System clock
  input wire srst, // Synchronous reset
  input wire cmd_valid, // Command strobe
  input wire [1:0] cmd, // Command code
  input wire [7:0] tx_byte, // Byte to write
  input wire send_ack, // Ack the byte being read
  input wire sda_in, // Synchronised data line
  output reg ready, // Idle, command accepted
  output reg done, // Command finished pulse
  output reg [7:0] rx_byte, // Byte read
  output reg nack, // Last write got no ack
  output reg scl_oe, // Pull clock low
  output reg sda_oe // Pull data low
);

  reg busy_reg;
  reg [1:0] cmd_reg;
  reg [15:0] div_reg;
  reg [1:0] ph_reg;
  reg [3:0] bit_reg;
  reg [7:0] sh_reg;
  reg ack_reg;
  wire last_bit = (bit_reg == 4'h8);
  wire is_read = (cmd_reg == `CMD_READ);
  // Data line pulled low for the current bit slot
  wire drive_low = last_bit ? (is_read & ack_reg) : (~is_read & ~sh_reg[7]);

  // Quarter-bit sequencer, one phase per divider tick
  always @(posedge clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      cmd_reg <= 2'h0;
      div_reg <= 16'h0000;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_reg <= 1'b0;
      ready <= 1'b1;
      done <= 1'b0;
      rx_byte <= 8'h00;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_reg) begin
        if (cmd_valid) begin
          busy_reg <= 1'b1;
          ready <= 1'b0;
          cmd_reg <= cmd;
          sh_reg <= tx_byte;
          ack_reg <= send_ack;
          nack <= 1'b0; // Stale nack must not leak into later steps
          ph_reg <= 2'h0;
          bit_reg <= 4'h0;
          div_reg <= 16'h0000;
        end
      end else if (div_reg == QUARTER[15:0] - 16'h0001) begin
        div_reg <= 16'h0000;
        ph_reg <= ph_reg + 2'h1;
        case (cmd_reg)
          `CMD_START: begin
            case (ph_reg)
              2'h0: begin
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
              end
              2'h1: sda_oe <= 1'b1;
              2'h2: scl_oe <= 1'b1;
              default: begin
                busy_reg <= 1'b0;
                ready <= 1'b1;
                done <= 1'b1;
              end
            endcase
          end
          `CMD_STOP: begin
            case (ph_reg)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: begin
                busy_reg <= 1'b0;
                ready <= 1'b1;
                done <= 1'b1;
              end
            endcase
          end
          default: begin
            case (ph_reg)
              2'h0: sda_oe <= drive_low;
              2'h1: scl_oe <= 1'b0;
              2'h2: begin
                if (last_bit) begin
                  nack <= sda_in & ~is_read;
                end else begin
                  sh_reg <= {sh_reg[6:0], sda_in};
                end
              end
              default: begin
                scl_oe <= 1'b1;
                if (last_bit) begin
                  busy_reg <= 1'b0;
                  ready <= 1'b1;
                  done <= 1'b1;
                  rx_byte <= sh_reg;
                end else begin
                  bit_reg <= bit_reg + 4'h1;
                end
              end
            endcase
          end
        endcase
      end else begin
        div_reg <= div_reg + 16'h0001;
      end
    end
  end

endmodule // i2c_byte_engine

// ---- hdl/id_rom_defs.vh ----
// Constants for the expansion board identification record reader.
// Assumes a 100 MHz system clock and a two-byte addressed I2C EEPROM.
`ifndef ID_ROM_DEFS_VH
`define ID_ROM_DEFS_VH

// Header bytes at offset 0
`define HDR_B0 8'hAA
`define HDR_B1 8'h55
`define HDR_B2 8'h33
`define HDR_B3 8'hEE
// Defined format revision, ASCII "A1"
`define REV_A1 16'h4131

// Field offsets, bytes
`define OFF_REV 8'h04
`define OFF_NAME 8'h06
`define OFF_VER 8'h26
`define OFF_MAKER 8'h2A
`define OFF_PART 8'h3A
`define OFF_PINCNT 8'h4A
`define OFF_SERIAL 8'h4C
`define OFF_PINS 8'h58
`define OFF_CUR_AUX 8'hEC
`define OFF_CUR_IN5 8'hEE
`define OFF_CUR_SYS5 8'hF0
`define OFF_SUPPLY 8'hF2
`define OFF_USER 8'hF4
`define LEN_USER 16'h7F1F
`define OFF_LAST 8'hF3

// Pin count limit
`define MAX_PINS 16'h005C

// Pin word field positions
`define PIN_USED_BIT 15
`define RSVD_HI 14
`define RSVD_LO 7
`define SLEW_BIT 6
`define RX_BIT 5
`define PULL_DIR_BIT 4
`define PULL_DIS_BIT 3
`define MUX_HI 2

// EEPROM address: base plus two jumper bits
`define I2C_ADDR_BASE 7'h54

// Byte engine commands
`define CMD_START 2'h0
`define CMD_STOP 2'h1
`define CMD_WRITE 2'h2
`define CMD_READ 2'h3

// Timing: system clock and SCL period in ns
`define CLK_PERIOD_NS 10
`define SCL_PERIOD_NS 10000
`define SCL_QUARTER_CYC (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))

`endif

// ---- hdl/id_rom_parser.v ----
// Functional notes
// R1 - Record opens with AA 55 33 EE
// R2 - Multi-byte fields are big-endian
// R3 - One byte per location, two-byte address
// R4 - Revision two ASCII bytes at 4, A1
// R5 - 32-byte board name at offset 6
// R6 - 4-byte hardware version at offset 38
// R7 - 16-byte maker name at offset 42
// R8 - 16-byte part number at offset 58
// R9 - Pin count at 74, at most 92
// R10 - 12-character serial number at offset 76
// R11 - 74 pin words from offset 88
// R12 - Three current limits at 236, 238, 240
// R13 - Supplied current at 242, zero none
// R14 - Bytes from 244 are free user space
// R15 - Bit 15 used, bits 14-7 reserved zero
// R16 - Bits 6-3 slew, receiver, pull select
// R17 - Bits 2-0 give mux mode
// R18 - Analog pins honour only used flag
// R19 - EEPROM at 0x54 to 0x57 by jumpers
// R20 - Bad header marks record invalid, stops
// R21 - High then low address, sequential reads
//
// Identification record reader for an expansion board EEPROM on I2C.
// Assumes start and addr_sel come from same-clock logic; sda_in is a pin.
`timescale 1ns/100ps
`include "id_rom_defs.vh"

module id_rom_parser #(
  parameter NUM_PINS = 74, // Configurable pin words
  parameter ANALOG_FIRST = 67, // First of the analog input pin words
  parameter QUARTER = `SCL_QUARTER_CYC // Clocks per quarter SCL bit
) (
  input wire clk, // System clock, 100 MHz
  input wire srst, // Synchronous reset, active high
  input wire start, // Begin a record read
  input wire [1:0] addr_sel, // Jumper address bits of the EEPROM
  input wire sda_in, // Data pin level
  output reg scl_o, // Clock pin value, always low
  output wire scl_oe, // Clock pin pull-down enable
  output reg sda_o, // Data pin value, always low
  output wire sda_oe, // Data pin pull-down enable
  output reg busy, // Read in progress
  output reg done, // Read finished pulse
  output reg record_valid, // Header good and all bytes read
  output reg header_bad, // Header did not match
  output reg nack_err, // EEPROM did not acknowledge
  output reg [15:0] revision, // Format revision, ASCII pair
  output reg rev_ok, // Revision is the defined one
  output reg [255:0] board_name, // Board name text
  output reg [31:0] hw_version, // Hardware version text
  output reg [127:0] maker_name, // Manufacturer text
  output reg [127:0] part_number, // Part number text
  output reg [15:0] pin_count, // Connector pins used
  output reg pin_count_ok, // Pin count within limit
  output reg [95:0] serial_number, // Serial number text
  output reg [15:0] aux_3v3_rail, // Max current, 3.3 V aux, mA
  output reg [15:0] input_5v_rail, // Max current, 5 V input, mA
  output reg [15:0] system_5v_rail, // Max current, system 5 V, mA
  output reg [15:0] supplied_current, // Current fed onto 5 V input, mA
  output reg supplies_power, // Board feeds the 5 V input
  input wire [6:0] pin_sel, // Pin word to show
  output reg [15:0] pin_word, // Raw pin word
  output reg pin_used, // Pin used by the board
  output reg pin_rsvd_err, // Reserved bits not zero
  output reg slew_rate_select, // Slow slew when set
  output reg rx_enable, // Receiver enabled
  output reg pull_direction_select, // Pull-up when set
  output reg pull_disable, // No pull when set
  output reg [2:0] mux_mode, // Multiplexer mode
  output reg pin_analog // Selected pin is an analog input
);

  localparam S_IDLE = 4'h0;
  localparam S_START = 4'h1;
  localparam S_DEVW = 4'h2;
  localparam S_MEMHI = 4'h3;
  localparam S_MEMLO = 4'h4;
  localparam S_RSTART = 4'h5;
  localparam S_DEVR = 4'h6;
  localparam S_READ = 4'h7;
  localparam S_STOP = 4'h8;

  reg [3:0] state_reg;
  reg wait_reg;
  reg cmd_valid_reg;
  reg abort_reg;
  reg [7:0] off_reg;
  reg [7:0] hi_byte_reg;
  reg sda_meta_reg;
  reg sda_sync_reg;
  reg [15:0] pin_mem [0:NUM_PINS-1];
  reg [1:0] eng_cmd;
  reg [7:0] eng_tx;
  reg eng_ack;
  wire eng_ready;
  wire eng_done;
  wire eng_nack;
  wire [7:0] eng_rx;
  wire [6:0] dev_addr = `I2C_ADDR_BASE | {5'h00, addr_sel}; // R19
  wire [7:0] pin_off = off_reg - `OFF_PINS;
  wire [6:0] pin_idx = pin_off[7:1];
  wire last_byte = (off_reg == `OFF_LAST); // R14

  // Offset falls in [lo, hi)
  function in_rng;
    input [7:0] off;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_rng = (off >= lo) && (off < hi);
    end
  endfunction

  // Expected header byte by offset
  function [7:0] hdr_byte;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: hdr_byte = `HDR_B0;
        2'h1: hdr_byte = `HDR_B1;
        2'h2: hdr_byte = `HDR_B2;
        default: hdr_byte = `HDR_B3;
      endcase
    end
  endfunction

  // Data pin synchroniser
  always @(posedge clk) begin
    if (srst) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // Bit-level bus driver
  i2c_byte_engine #(
    .QUARTER(QUARTER)
  ) u_engine (
    .clk(clk),
    .srst(srst),
    .cmd_valid(cmd_valid_reg),
    .cmd(eng_cmd),
    .tx_byte(eng_tx),
    .send_ack(eng_ack),
    .sda_in(sda_sync_reg),
    .ready(eng_ready),
    .done(eng_done),
    .rx_byte(eng_rx),
    .nack(eng_nack),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  // Command for the current step
  always @* begin
    eng_cmd = `CMD_READ;
    eng_tx = 8'h00;
    eng_ack = 1'b0;
    case (state_reg)
      S_START: eng_cmd = `CMD_START;
      S_RSTART: eng_cmd = `CMD_START;
      S_STOP: eng_cmd = `CMD_STOP;
      S_DEVW: begin
        eng_cmd = `CMD_WRITE;
        eng_tx = {dev_addr[6:0], 1'b0};
      end
      S_MEMHI: eng_cmd = `CMD_WRITE; // R21
      S_MEMLO: eng_cmd = `CMD_WRITE; // R3
      S_DEVR: begin
        eng_cmd = `CMD_WRITE;
        eng_tx = {dev_addr[6:0], 1'b1};
      end
      S_READ: eng_ack = ~(abort_reg | last_byte); // R21
      default: eng_cmd = `CMD_READ;
    endcase
  end

  // Transfer sequencer
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
      wait_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      abort_reg <= 1'b0;
      off_reg <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      record_valid <= 1'b0;
      header_bad <= 1'b0;
      nack_err <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      cmd_valid_reg <= 1'b0;
      done <= 1'b0;
      if (state_reg == S_IDLE) begin
        if (start) begin
          state_reg <= S_START;
          wait_reg <= 1'b0;
          abort_reg <= 1'b0;
          off_reg <= 8'h00;
          busy <= 1'b1;
          record_valid <= 1'b0;
          header_bad <= 1'b0;
          nack_err <= 1'b0;
        end
      end else if (!wait_reg) begin
        if (eng_ready) begin
          cmd_valid_reg <= 1'b1;
          wait_reg <= 1'b1;
        end
      end else if (eng_done) begin
        wait_reg <= 1'b0;
        case (state_reg)
          S_START: state_reg <= S_DEVW;
          S_DEVW: state_reg <= eng_nack ? S_STOP : S_MEMHI;
          S_MEMHI: state_reg <= eng_nack ? S_STOP : S_MEMLO;
          S_MEMLO: state_reg <= eng_nack ? S_STOP : S_RSTART;
          S_RSTART: state_reg <= S_DEVR;
          S_DEVR: state_reg <= eng_nack ? S_STOP : S_READ;
          S_READ: begin
            if (abort_reg || last_byte) begin
              state_reg <= S_STOP; // R14
            end else begin
              off_reg <= off_reg + 8'h01; // R21
            end
            // Header mismatch ends the read after one nacked byte
            if (!abort_reg && off_reg < `OFF_REV && eng_rx != hdr_byte(off_reg[1:0])) begin
              abort_reg <= 1'b1; // R20
              header_bad <= 1'b1; // R1
            end
          end
          default: begin
            state_reg <= S_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            record_valid <= ~abort_reg & ~nack_err;
          end
        endcase
        if (eng_nack && state_reg != S_READ && state_reg != S_STOP) begin
          nack_err <= 1'b1;
        end
      end
    end
  end

  // Field capture, each field shifted in most significant byte first
  always @(posedge clk) begin
    if (srst) begin
      revision <= 16'h0000;
      rev_ok <= 1'b0;
      board_name <= 256'h0;
      hw_version <= 32'h0000_0000;
      maker_name <= 128'h0;
      part_number <= 128'h0;
      pin_count <= 16'h0000;
      pin_count_ok <= 1'b0;
      serial_number <= 96'h0;
      aux_3v3_rail <= 16'h0000;
      input_5v_rail <= 16'h0000;
      system_5v_rail <= 16'h0000;
      supplied_current <= 16'h0000;
      supplies_power <= 1'b0;
      hi_byte_reg <= 8'h00;
    end else begin
      rev_ok <= (revision == `REV_A1); // R4
      pin_count_ok <= (pin_count <= `MAX_PINS); // R9
      supplies_power <= (supplied_current != 16'h0000); // R13
      if (eng_done && state_reg == S_READ && !abort_reg) begin
        if (in_rng(off_reg, `OFF_REV, `OFF_NAME)) begin
          revision <= {revision[7:0], eng_rx}; // R4
        end
        if (in_rng(off_reg, `OFF_NAME, `OFF_VER)) begin
          board_name <= {board_name[247:0], eng_rx}; // R5
        end
        if (in_rng(off_reg, `OFF_VER, `OFF_MAKER)) begin
          hw_version <= {hw_version[23:0], eng_rx}; // R6
        end
        if (in_rng(off_reg, `OFF_MAKER, `OFF_PART)) begin
          maker_name <= {maker_name[119:0], eng_rx}; // R7
        end
        if (in_rng(off_reg, `OFF_PART, `OFF_PINCNT)) begin
          part_number <= {part_number[119:0], eng_rx}; // R8
        end
        if (in_rng(off_reg, `OFF_PINCNT, `OFF_SERIAL)) begin
          pin_count <= {pin_count[7:0], eng_rx}; // R2
        end
        if (in_rng(off_reg, `OFF_SERIAL, `OFF_PINS)) begin
          serial_number <= {serial_number[87:0], eng_rx}; // R10
        end
        if (in_rng(off_reg, `OFF_PINS, `OFF_CUR_AUX) && !pin_off[0]) begin
          hi_byte_reg <= eng_rx; // R2
        end
        if (in_rng(off_reg, `OFF_CUR_AUX, `OFF_CUR_IN5)) begin
          aux_3v3_rail <= {aux_3v3_rail[7:0], eng_rx}; // R12
        end
        if (in_rng(off_reg, `OFF_CUR_IN5, `OFF_CUR_SYS5)) begin
          input_5v_rail <= {input_5v_rail[7:0], eng_rx}; // R12
        end
        if (in_rng(off_reg, `OFF_CUR_SYS5, `OFF_SUPPLY)) begin
          system_5v_rail <= {system_5v_rail[7:0], eng_rx}; // R12
        end
        if (in_rng(off_reg, `OFF_SUPPLY, `OFF_USER)) begin
          supplied_current <= {supplied_current[7:0], eng_rx}; // R13
        end
      end
    end
  end

  // Pin word store, written on the low byte of each pair
  always @(posedge clk) begin
    if (eng_done && state_reg == S_READ && !abort_reg && pin_off[0] &&
        in_rng(off_reg, `OFF_PINS, `OFF_CUR_AUX)) begin
      pin_mem[pin_idx] <= {hi_byte_reg, eng_rx}; // R11
    end
  end

  // Decoded view of the selected pin word
  always @(posedge clk) begin
    if (srst) begin
      pin_word <= 16'h0000;
      pin_used <= 1'b0;
      pin_rsvd_err <= 1'b0;
      slew_rate_select <= 1'b0;
      rx_enable <= 1'b0;
      pull_direction_select <= 1'b0;
      pull_disable <= 1'b0;
      mux_mode <= 3'h0;
      pin_analog <= 1'b0;
    end else if (!record_valid || pin_sel >= NUM_PINS[6:0]) begin
      pin_word <= 16'h0000;
      pin_used <= 1'b0;
      pin_rsvd_err <= 1'b0;
      slew_rate_select <= 1'b0;
      rx_enable <= 1'b0;
      pull_direction_select <= 1'b0;
      pull_disable <= 1'b0;
      mux_mode <= 3'h0;
      pin_analog <= 1'b0;
    end else begin
      pin_word <= pin_mem[pin_sel];
      pin_used <= pin_mem[pin_sel][`PIN_USED_BIT]; // R15
      pin_analog <= (pin_sel >= ANALOG_FIRST[6:0]);
      if (pin_sel >= ANALOG_FIRST[6:0]) begin
        pin_rsvd_err <= 1'b0; // R18
        slew_rate_select <= 1'b0; // R18
        rx_enable <= 1'b0;
        pull_direction_select <= 1'b0;
        pull_disable <= 1'b0;
        mux_mode <= 3'h0;
      end else begin
        pin_rsvd_err <= |pin_mem[pin_sel][`RSVD_HI:`RSVD_LO]; // R15
        slew_rate_select <= pin_mem[pin_sel][`SLEW_BIT]; // R16
        rx_enable <= pin_mem[pin_sel][`RX_BIT]; // R16
        pull_direction_select <= pin_mem[pin_sel][`PULL_DIR_BIT]; // R16
        pull_disable <= pin_mem[pin_sel][`PULL_DIS_BIT]; // R16
        mux_mode <= pin_mem[pin_sel][`MUX_HI:0]; // R17
      end
    end
  end

endmodule // id_rom_parser

// ---- tb/eeprom_model.sv ----
// Two-byte addressed serial EEPROM on an open-drain bus, sampled by clk.
// Assumes pulled-up wires; sda_pull high pulls the data line low.
`timescale 1ns/100ps

module eeprom_model #(
  parameter [6:0] DEV = 7'h56 // Jumper-set bus address
) (
  input wire clk, // Sampling clock
  input wire scl, // Bus clock level
  input wire sda, // Bus data level
  output reg sda_pull // Pulls data low
);
  reg [7:0] mem [0:255];
  reg [7:0] sh = 8'h00;
  reg [15:0] ptr = 16'h0000;
  reg [15:0] ptr_start = 16'hFFFF;
  reg [3:0] bitn = 4'h0;
  reg [1:0] byt = 2'h0;
  reg scl_q = 1'b1;
  reg sda_q = 1'b1;
  reg act = 1'b0;
  reg tx = 1'b0;
  integer nsent = 0;
  initial sda_pull = 1'b0;

  // Edge tracker: start and stop, shift in on rise, drive on fall
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl_q && scl && sda_q && !sda) begin
      act <= 1'b1;
      tx <= 1'b0;
      bitn <= 4'h0;
      byt <= 2'h0;
      sda_pull <= 1'b0;
    end else if (scl_q && scl && !sda_q && sda) begin
      act <= 1'b0;
      sda_pull <= 1'b0;
    end else if (act && scl && !scl_q) begin
      if (!tx && bitn < 4'h8) sh <= {sh[6:0], sda};
      if (tx && bitn == 4'h8 && sda) act <= 1'b0; // Master nack ends the read
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
    end else if (act && !scl && scl_q) begin
      if (bitn == 4'h8 && tx) sda_pull <= 1'b0;
      else if (bitn == 4'h8) begin
        sda_pull <= (byt != 2'h0) || (sh[7:1] == DEV);
        act <= (byt != 2'h0) || (sh[7:1] == DEV);
        if (byt == 2'h0) tx <= sh[0];
        if (byt == 2'h1) ptr[15:8] <= sh;
        if (byt == 2'h2) begin
          ptr[7:0] <= sh;
          ptr_start <= {ptr[15:8], sh};
        end
        byt <= byt + 2'h1;
      end else if (bitn == 4'h0 && tx) begin
        sda_pull <= !mem[ptr[7:0]][7];
        sh <= {mem[ptr[7:0]][6:0], 1'b0};
        ptr <= ptr + 16'h0001;
        nsent <= nsent + 1;
      end else if (tx) begin
        sda_pull <= !sh[7];
        sh <= {sh[6:0], 1'b0};
      end else sda_pull <= 1'b0;
    end
  end
endmodule // eeprom_model

// ---- tb/id_rom_parser_props.sv ----
// Concurrent checks on the identification record reader's ports.
// Assumes one clock domain with synchronous active-high reset; bound below.
`timescale 1ns/100ps
`include "id_rom_defs.vh"

module id_rom_parser_props #(
  parameter NUM_PINS = 74, // Pin words
  parameter ANALOG_FIRST = 67 // First analog word
) (
  input wire clk, // Clock
  input wire srst, // Reset
  input wire [6:0] pin_sel, // Word index
  input wire scl_oe, // Clock pull
  input wire sda_oe, // Data pull
  input wire busy, // Busy
  input wire done, // Done pulse
  input wire record_valid, // Record good
  input wire header_bad, // Header bad
  input wire nack_err, // No ack
  input wire [15:0] revision, // Revision
  input wire rev_ok, // Revision good
  input wire [15:0] pin_count, // Pin count
  input wire pin_count_ok, // Count good
  input wire [15:0] supplied_current, // Supplied mA
  input wire supplies_power, // Feeds 5 V
  input wire [15:0] pin_word, // Raw word
  input wire pin_used, // Used
  input wire pin_rsvd_err, // Reserved set
  input wire slew_rate_select, // Slow slew
  input wire rx_enable, // Receiver
  input wire pull_direction_select, // Pull-up
  input wire pull_disable, // No pull
  input wire [2:0] mux_mode, // Mux mode
  input wire pin_analog // Analog pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Read begin, then bus conditions: data moves while the clock line is released
  sequence s_begin;
    !busy ##1 busy;
  endsequence
  sequence s_start_cond;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_stop_cond;
    $fell(sda_oe) && !scl_oe;
  endsequence

  property p_start;
    s_begin |-> !scl_oe ##[0:1000] s_start_cond;
  endproperty
  a_start: assert property (p_start) else $error("no start condition after read began");
  property p_stop;
    s_stop_cond |-> ##[1:1000] done;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not followed by done");
  property p_valid;
    done |-> record_valid == (!header_bad && !nack_err);
  endproperty
  a_valid: assert property (p_valid) else $error("record_valid wrong at done");
  property p_rev;
    rev_ok == ($past(revision) == `REV_A1);
  endproperty
  a_rev: assert property (p_rev) else $error("rev_ok does not follow revision");
  property p_pincnt;
    done |-> pin_count_ok == (pin_count <= `MAX_PINS);
  endproperty
  a_pincnt: assert property (p_pincnt) else $error("pin_count_ok wrong");
  property p_power;
    done |-> supplies_power == (supplied_current != 16'h0000);
  endproperty
  a_power: assert property (p_power) else $error("supplies_power wrong");
  property p_zero;
    (!$past(record_valid) || $past(pin_sel) >= NUM_PINS) |-> pin_word == 16'h0000 && !pin_used && !pin_analog;
  endproperty
  a_zero: assert property (p_zero) else $error("pin outputs not zero");
  property p_decode;
    !pin_analog |-> {pin_used, pin_rsvd_err, slew_rate_select, rx_enable, pull_direction_select, pull_disable,
      mux_mode} == {pin_word[15], |pin_word[14:7], pin_word[6:0]};
  endproperty
  a_decode: assert property (p_decode) else $error("pin word decode wrong");
  property p_analog;
    ($past(record_valid) && $past(pin_sel) >= ANALOG_FIRST && $past(pin_sel) < NUM_PINS) |-> pin_analog &&
      pin_used == pin_word[15] && {pin_rsvd_err, slew_rate_select, rx_enable, pull_direction_select, pull_disable,
      mux_mode} == 8'h00;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin decode wrong");
endmodule // id_rom_parser_props

bind id_rom_parser id_rom_parser_props #(.NUM_PINS(NUM_PINS), .ANALOG_FIRST(ANALOG_FIRST)) u_props (.clk, .srst,
  .pin_sel, .scl_oe, .sda_oe, .busy, .done, .record_valid, .header_bad, .nack_err, .revision, .rev_ok, .pin_count,
  .pin_count_ok, .supplied_current, .supplies_power, .pin_word, .pin_used, .pin_rsvd_err, .slew_rate_select,
  .rx_enable, .pull_direction_select, .pull_disable, .mux_mode, .pin_analog);

// ---- tb/tb_id_rom_parser.sv ----
// Self-checking bench for the identification record reader.
// Assumes the EEPROM model answers at jumper setting 2; short bus phases.
`timescale 1ns/100ps

module tb_id_rom_parser;
  reg clk;
  reg srst = 1'b1;
  reg start = 1'b0;
  reg [1:0] addr_sel = 2'h1;
  reg [6:0] pin_sel = 7'h00;
  wire scl_o, scl_oe, sda_o, sda_oe, busy, done, record_valid, header_bad, nack_err, rev_ok, pin_count_ok;
  wire supplies_power, pin_used, pin_rsvd_err, slew_rate_select, rx_enable, pull_direction_select, pull_disable;
  wire pin_analog, mdl_pull;
  wire [15:0] revision, pin_count, aux_3v3_rail, input_5v_rail, system_5v_rail, supplied_current, pin_word;
  wire [255:0] board_name;
  wire [31:0] hw_version;
  wire [127:0] maker_name, part_number;
  wire [95:0] serial_number;
  wire [2:0] mux_mode;
  wire scl = scl_oe ? 1'b0 : 1'b1;
  wire sda = (sda_oe || mdl_pull) ? 1'b0 : 1'b1;
  reg [7:0] img [0:255];
  integer miscompares = 0;
  integer n_compared = 0;
  integer i, j;
  integer sels [0:7] = '{0, 1, 2, 66, 67, 70, 73, 74};

  id_rom_parser #(.QUARTER(4)) uut (.clk, .srst, .start, .addr_sel, .sda_in(sda), .scl_o, .scl_oe, .sda_o,
    .sda_oe, .busy, .done, .record_valid, .header_bad, .nack_err, .revision, .rev_ok, .board_name, .hw_version,
    .maker_name, .part_number, .pin_count, .pin_count_ok, .serial_number, .aux_3v3_rail, .input_5v_rail,
    .system_5v_rail, .supplied_current, .supplies_power, .pin_sel, .pin_word, .pin_used, .pin_rsvd_err,
    .slew_rate_select, .rx_enable, .pull_direction_select, .pull_disable, .mux_mode, .pin_analog);
  eeprom_model #(.DEV(7'h56)) mdl (.clk(clk), .scl(scl), .sda(sda), .sda_pull(mdl_pull));

  // Clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Big-endian field from the bench image
  function [255:0] be(input integer off, input integer n);
    integer k;
    begin
      be = 256'h0;
      for (k = 0; k < n; k = k + 1) be = {be[247:0], img[off + k]};
    end
  endfunction

  // Expected decoded pin outputs
  function [25:0] pexp(input integer k);
    reg [15:0] w;
    begin
      w = be(88 + 2 * (k % 74), 2);
      if (k >= 74) pexp = 26'h0;
      else if (k >= 67) pexp = {w, w[15], 8'h00, 1'b1};
      else pexp = {w, w[15], |w[14:7], w[6:0], 1'b0};
    end
  endfunction

  task chk(input [255:0] got, input [255:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask

  // Starts a read, optionally pokes start while busy, waits for done
  task rd_record(input integer poke);
    integer t;
    begin
      @(posedge clk) #1 start = 1'b1;
      @(posedge clk) #1 start = 1'b0;
      chk(busy, 1'b1);
      if (poke > 0) begin
        repeat (poke) @(posedge clk);
        #1 start = 1'b1;
        @(posedge clk) #1 start = 1'b0;
      end
      t = 0;
      while (done !== 1'b1 && t < 60000) begin
        @(posedge clk) #1 t = t + 1;
      end
      chk(t < 60000, 1'b1);
    end
  endtask

  task results;
    begin
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Watchdog
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results;
  end

  // Main sequence
  initial begin
    for (i = 0; i < 256; i = i + 1) img[i] = 8'(i) ^ 8'hC3;
    img[0] = 8'hAA;
    img[1] = 8'h55;
    img[2] = 8'h34;
    img[3] = 8'hEE;
    img[4] = 8'h41;
    img[5] = 8'h31;
    img[74] = 8'h00;
    img[75] = 8'h5C;
    {img[88], img[89], img[90], img[91]} = 32'h807D_0180;
    {img[228], img[229], img[242], img[243]} = 32'h807F_0145;
    for (i = 0; i < 256; i = i + 1) mdl.mem[i] = img[i];
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    // Wrong jumper setting, no acknowledge
    rd_record(0);
    chk(nack_err, 1'b1);
    chk(record_valid, 1'b0);
    chk({pin_word, scl_o, sda_o}, 18'h0);
    // Broken header stops the read
    addr_sel = 2'h2;
    rd_record(0);
    chk({header_bad, nack_err, record_valid}, 3'b100);
    chk(revision, 16'h0000);
    // Full record, with a refused start in mid-read
    img[2] = 8'h33;
    mdl.mem[2] = 8'h33;
    rd_record(3000);
    chk({record_valid, header_bad, nack_err}, 3'b100);
    chk(mdl.ptr_start, 16'h0000);
    chk(mdl.nsent, 4 + 244);
    chk({revision, rev_ok}, {be(4, 2), 1'b1});
    chk(board_name, be(6, 32));
    chk(hw_version, be(38, 4));
    chk(maker_name, be(42, 16));
    chk(part_number, be(58, 16));
    chk({pin_count, pin_count_ok}, {be(74, 2), 1'b1});
    chk(serial_number, be(76, 12));
    chk({aux_3v3_rail, input_5v_rail, system_5v_rail}, be(236, 6));
    chk({supplied_current, supplies_power}, {be(242, 2), 1'b1});
    for (j = 0; j < 8; j = j + 1) begin
      pin_sel = sels[j][6:0];
      repeat (2) @(posedge clk);
      #1 chk({pin_word, pin_used, pin_rsvd_err, slew_rate_select, rx_enable, pull_direction_select, pull_disable,
        mux_mode, pin_analog}, pexp(sels[j]));
    end
    results;
  end
endmodule // tb_id_rom_parser
